// >>> crc8_step.v
// one byte of the frame checksum, combinational
// assumes the caller holds the running value between bytes
`timescale 1ns/1ns
`default_nettype none
`include "dac_setup_regs.vh"

module crc8_step (
	// running value and new byte
	input wire [7:0] crc_in,
	input wire [7:0] data_in,
	// updated value
	output reg [7:0] crc_out
);
	integer i;
	reg [7:0] c;

	always @* begin
		c = crc_in ^ data_in;
		for (i = 0; i < 8; i = i + 1) begin
			if (c[7]) begin
				c = {c[6:0], 1'b0} ^ `CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		crc_out = c;
	end
endmodule // crc8_step

`default_nettype wire

// >>> dac_setup.v
// dac configuration registers, serial frame decoder with checksum, code to voltage
// assumes one AHB-Lite master, synchronous serial byte strobes, hclk at 50 MHz
`timescale 1ns/1ns
`default_nettype none
`include "dac_setup_regs.vh"

module dac_setup #(
	parameter CODE_W = 16
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// serial frame input
	input wire frame_start,
	input wire rx_valid,
	input wire [7:0] rx_byte,
	// serial data output
	output reg [15:0] sdo_data,
	output reg sdo_valid,
	output reg sdo_oe,
	// converter and dac state
	output reg [CODE_W-1:0] dac_code,
	output reg [21:0] vout_uv,
	output reg crc_enabled,
	output reg converter_buffer_on
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [15:0] config_reg;
	reg [15:0] conv_cfg;
	reg [CODE_W-1:0] code_reg;
	reg crc_err;
	reg [15:0] next_config;
	reg [15:0] next_conv;
	reg [CODE_W-1:0] next_code;
	reg next_crc_err;

	// ----------------------------------------------------------------
	// ahb address phase capture
	// ----------------------------------------------------------------
	reg wr_pend;
	reg [3:0] wr_idx;
	wire take = hsel & htrans[1] & hready;
	wire [3:0] a_idx = haddr[5:2];
	wire a_map = (haddr[31:6] == 26'h0000000) & (haddr[1:0] == 2'b00);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_idx <= 4'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready) begin
				wr_pend <= take & hwrite & a_map;
				wr_idx <= a_idx;
			end
		end
	end

	// ----------------------------------------------------------------
	// serial frame decode
	// ----------------------------------------------------------------
	reg [1:0] byte_cnt;
	reg [7:0] cmd;
	reg [7:0] data_hi;
	reg [7:0] data_lo;
	reg [7:0] crc_run;
	reg frame_done;
	wire [7:0] crc_next;

	crc8_step u_crc (
		.crc_in(crc_run),
		.data_in(rx_byte),
		.crc_out(crc_next)
	);

	// a frame finishes on its third byte when unchecked, else on the fourth
	// bytes past the end of a frame are dropped until the next start,
	// else a trailing byte would re-judge the frame against a stale count
	wire byte_in = rx_valid & ~frame_done;
	wire last_plain = byte_in & (byte_cnt == 2'd2) & ~config_reg[`CFG_CRC_EN_BIT];
	wire last_crc = byte_in & (byte_cnt == 2'd3) & config_reg[`CFG_CRC_EN_BIT];
	wire crc_ok = (crc_run == rx_byte);
	wire frame_go = last_plain | (last_crc & crc_ok);
	wire frame_bad = last_crc & ~crc_ok;
	wire [7:0] f_cmd = last_plain ? cmd : cmd;
	wire [7:0] f_lo = last_plain ? rx_byte : data_lo;
	wire [15:0] f_data = {data_hi, f_lo};
	wire f_read = f_cmd[`CMD_READ_BIT];
	wire [3:0] f_idx = f_cmd[3:0];
	wire f_map = (f_cmd[6:4] == 3'b000);
	wire ser_wr = frame_go & ~f_read & f_map;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			byte_cnt <= 2'd0;
			cmd <= 8'h00;
			data_hi <= 8'h00;
			data_lo <= 8'h00;
			crc_run <= `CRC_INIT;
			frame_done <= 1'b0;
		end else if (frame_start) begin
			byte_cnt <= 2'd0;
			crc_run <= `CRC_INIT;
			frame_done <= 1'b0;
		end else if (rx_valid) begin
			crc_run <= crc_next;
			if (last_plain | last_crc) begin
				frame_done <= 1'b1;
			end
			if (byte_cnt != 2'd3) begin
				byte_cnt <= byte_cnt + 2'd1;
			end
			case (byte_cnt)
				2'd0: begin
					cmd <= rx_byte;
				end
				2'd1: begin
					data_hi <= rx_byte;
				end
				2'd2: begin
					data_lo <= rx_byte;
				end
				default: begin
					cmd <= cmd;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register update, serial write then bus write, bus write wins
	// ----------------------------------------------------------------
	always @* begin
		next_config = config_reg;
		next_conv = conv_cfg;
		next_code = code_reg;
		next_crc_err = crc_err | frame_bad;
		if (ser_wr) begin
			case (f_idx)
				`IDX_DAC_CODE: begin
					next_code = f_data[CODE_W-1:0];
				end
				`IDX_CONFIG: begin
					next_config = f_data;
				end
				`IDX_CONV_CFG: begin
					next_conv = f_data;
				end
				default: begin
					next_code = next_code;
				end
			endcase
		end
		if (wr_pend) begin
			case (wr_idx)
				`IDX_DAC_CODE: begin
					next_code = hwdata[CODE_W-1:0];
				end
				`IDX_CONFIG: begin
					next_config = hwdata[15:0];
				end
				`IDX_CONV_CFG: begin
					next_conv = hwdata[15:0];
				end
				`IDX_STATUS: begin
					// write one clears, a new checksum fault wins
					next_crc_err = (crc_err & ~hwdata[`STAT_CRC_ERR_BIT]) | frame_bad;
				end
				default: begin
					next_code = next_code;
				end
			endcase
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			config_reg <= `CFG_RESET;
			conv_cfg <= `CONV_RESET;
			code_reg <= `DAC_CODE_RESET;
			crc_err <= 1'b0;
		end else begin
			config_reg <= next_config;
			conv_cfg <= next_conv;
			code_reg <= next_code;
			crc_err <= next_crc_err;
		end
	end

	// ----------------------------------------------------------------
	// code classes and status word
	// ----------------------------------------------------------------
	wire [15:0] code16 = code_reg;
	wire in_range = (code16 >= `CODE_RANGE_MIN) & (code16 <= `CODE_RANGE_MAX);
	wire err_low = (code16 == `CODE_ERR_LOW);
	wire err_high = (code16 == `CODE_ERR_HIGH);
	wire [15:0] status_word = {10'h000, ~config_reg[`CFG_SERIAL_OUT_DISABLE_BIT],
		config_reg[`CFG_CRC_EN_BIT], err_high, err_low, in_range, crc_err};

	function [15:0] reg_value;
		input [3:0] idx;
		begin
			case (idx)
				`IDX_DAC_CODE: begin
					reg_value = next_code;
				end
				`IDX_CONFIG: begin
					reg_value = next_config;
				end
				`IDX_CONV_CFG: begin
					reg_value = next_conv;
				end
				`IDX_STATUS: begin
					reg_value = status_word;
				end
				default: begin
					reg_value = 16'h0000;
				end
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// read data, bus and serial
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			sdo_data <= 16'h0000;
			sdo_valid <= 1'b0;
		end else begin
			if (take & ~hwrite) begin
				hrdata <= a_map ? {16'h0000, reg_value(a_idx)} : 32'h00000000;
			end
			// a read answers only while the output driver is on
			sdo_valid <= frame_go & f_read & ~config_reg[`CFG_SERIAL_OUT_DISABLE_BIT];
			if (frame_go & f_read & ~config_reg[`CFG_SERIAL_OUT_DISABLE_BIT]) begin
				sdo_data <= f_map ? reg_value(f_idx) : 16'h0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs: driver enable, converter buffer, dac voltage
	// ----------------------------------------------------------------
	wire [37:0] span_prod = {22'h000000, code16} * {16'h0000, `VOUT_SPAN_UV};
	wire [21:0] span_uv = span_prod[37:`CODE_SHIFT];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sdo_oe <= 1'b0;
			crc_enabled <= 1'b1;
			converter_buffer_on <= 1'b0;
			dac_code <= `DAC_CODE_RESET;
			vout_uv <= `VOUT_MIN_UV;
		end else begin
			sdo_oe <= ~config_reg[`CFG_SERIAL_OUT_DISABLE_BIT];
			crc_enabled <= config_reg[`CFG_CRC_EN_BIT];
			converter_buffer_on <= ~conv_cfg[`CONV_BUFFER_POWERDOWN_BIT];
			dac_code <= code_reg;
			vout_uv <= `VOUT_MIN_UV + span_uv;
		end
	end

endmodule // dac_setup

`default_nettype wire

// >>> dac_setup_assertions.sv
// port assertions for the dac setup block
// assumes a bind onto dac_setup, one clock hclk
`timescale 1ns/1ns
`default_nettype none
module dac_setup_assertions #(
	parameter CODE_W = 16
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// serial and state
	input wire logic rx_valid,
	input wire logic sdo_valid,
	input wire logic sdo_oe,
	input wire logic [CODE_W-1:0] dac_code,
	input wire logic [21:0] vout_uv,
	input wire logic crc_enabled,
	input wire logic converter_buffer_on
);
	logic wr_dp;
	logic [3:0] act;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----------------------------------------
	// recent bus write or serial byte
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_dp <= 1'b0;
			act <= 4'h0;
		end else begin
			wr_dp <= hsel & htrans[1] & hready & hwrite;
			act <= {act[2:0], wr_dp | rx_valid};
		end
	end
	property p_rst_state;
		$rose(hresetn) |-> crc_enabled && !sdo_oe && !converter_buffer_on;
	endproperty
	a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
	property p_ans_oe;
		sdo_valid |-> sdo_oe && $past(rx_valid);
	endproperty
	a_ans_oe: assert property (p_ans_oe) else $error("answer without output");
	property p_ans_pulse;
		sdo_valid |=> !sdo_valid;
	endproperty
	a_ans_pulse: assert property (p_ans_pulse) else $error("answer too long");
	property p_vout_lin;
		$stable(dac_code) |-> vout_uv == 22'd300000 + 22'((44'(dac_code) * 44'd2200000) >> 16);
	endproperty
	a_vout_lin: assert property (p_vout_lin) else $error("vout not linear");
	property p_vout_span;
		vout_uv >= 22'd300000 && vout_uv <= 22'd2500000;
	endproperty
	a_vout_span: assert property (p_vout_span) else $error("vout out of span");
	property p_oe_cause;
		$changed(sdo_oe) |-> |act;
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("output enable moved alone");
	property p_crc_cause;
		$changed(crc_enabled) |-> |act;
	endproperty
	a_crc_cause: assert property (p_crc_cause) else $error("checksum moved alone");
	property p_buf_cause;
		$changed(converter_buffer_on) |-> |act;
	endproperty
	a_buf_cause: assert property (p_buf_cause) else $error("buffer moved alone");
	property p_bus_okay;
		hreadyout && !hresp && hrdata[31:16] == 16'h0000;
	endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus answer wrong");
	c_answer: cover property (sdo_valid);
	c_crc_off: cover property ($fell(crc_enabled));
	c_buf_on: cover property ($rose(converter_buffer_on));
endmodule // dac_setup_assertions
`default_nettype wire

// >>> dac_setup_regs.vh
// register map, field positions, reset values and code levels of the dac setup block
// assumes a 50 MHz hclk and AHB-Lite word access; included by bare name
`ifndef DAC_SETUP_REGS_VH
`define DAC_SETUP_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_DAC_CODE 4'h1
`define IDX_CONFIG 4'h2
`define IDX_CONV_CFG 4'h3
`define IDX_STATUS 4'h4

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CFG_CRC_EN_BIT 0
`define CFG_SERIAL_OUT_DISABLE_BIT 5
`define CFG_RESET 16'h0021
`define CONV_BUFFER_POWERDOWN_BIT 0
`define CONV_RESET 16'h0001
`define DAC_CODE_RESET 16'h0000
`define STAT_CRC_ERR_BIT 0
`define STAT_IN_RANGE_BIT 1
`define STAT_ERR_LOW_BIT 2
`define STAT_ERR_HIGH_BIT 3
`define STAT_CRC_EN_BIT 4
`define STAT_SDO_ON_BIT 5

// ----------------------------------------------------------------
// checksum and serial command layout
// ----------------------------------------------------------------
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00
`define CMD_READ_BIT 7

// ----------------------------------------------------------------
// output transfer: microvolts
// ----------------------------------------------------------------
`define VOUT_MIN_UV 22'd300000
`define VOUT_SPAN_UV 22'd2200000
`define CODE_SHIFT 16

// ----------------------------------------------------------------
// loop signalling codes
// ----------------------------------------------------------------
`define CODE_ERR_LOW 16'h045d
`define CODE_RANGE_MIN 16'h0ba2
`define CODE_RANGE_MID 16'h68ba
`define CODE_RANGE_MAX 16'hc5d1
`define CODE_ERR_HIGH 16'hda2e

`endif

// >>> dac_setup_test.sv
// self-checking bench for the dac setup block
// assumes dac_setup, serial_host and the checker beside it
`timescale 1ns/1ns
`default_nettype none
`include "dac_setup_regs.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
	$display("BAD %0t %h %h", $time, (a), (e)); end end
module dac_setup_test;
	localparam logic [31:0] a_dac = {26'h0, `IDX_DAC_CODE, 2'b00};
	localparam logic [31:0] a_cfg = {26'h0, `IDX_CONFIG, 2'b00};
	localparam logic [31:0] a_conv = {26'h0, `IDX_CONV_CFG, 2'b00};
	localparam logic [31:0] a_stat = {26'h0, `IDX_STATUS, 2'b00};
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
	logic [15:0] got;
	wire logic [31:0] hrdata;
	wire logic [15:0] sdo_data, dac_code;
	wire logic [21:0] vout_uv;
	wire logic [7:0] rx_byte;
	wire logic hreadyout, hresp, sdo_valid, sdo_oe, crc_enabled, converter_buffer_on;
	wire logic frame_start, rx_valid;
	int n_fail = 0, n_tests = 0, nval = 0;
	always #10 hclk = ~hclk;
	dac_setup dut (.hready(hreadyout), .hsize(3'h2), .*);
	serial_host host (.*);
	always @(posedge hclk) begin
		if (sdo_valid === 1'b1) begin
			got <= sdo_data;
			nval++;
		end
	end
	// ----------------------------------------
	// bus transfer and scenarios
	// ----------------------------------------
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk) hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic t_reset;
		xfer(a_cfg, 0, 0);
		`CHK(r, {16'h0, `CFG_RESET})
		`CHK(crc_enabled, 1'b1)
		`CHK(sdo_oe, 1'b0)
		`CHK(vout_uv, 22'd300000)
		xfer(a_conv, 0, 0);
		`CHK(r, {16'h0, `CONV_RESET})
		xfer(32'h40, 0, 0);
		`CHK(r, 32'h0)
	endtask
	task automatic t_crc;
		host.send(8'h02, 8'h00, 8'h26, 4, 1'b1);
		host.send(8'h82, 8'h00, 8'h00, 4, 1'b0);
		repeat (3) @(posedge hclk);
		`CHK(crc_enabled, 1'b1)
		`CHK(nval, 0)
		xfer(a_stat, 0, 0);
		`CHK(r[0], 1'b1)
		xfer(a_stat, 1, 32'h1);
		host.send(8'h02, 8'h00, 8'h26, 4, 1'b0);
		repeat (3) @(posedge hclk);
		`CHK(crc_enabled, 1'b0)
		xfer(a_stat, 0, 0);
		`CHK(r[5:0], 6'h00)
	endtask
	task automatic t_sdo;
		xfer(a_cfg, 1, 32'h6);
		repeat (3) @(posedge hclk);
		`CHK(sdo_oe, 1'b1)
		host.send(8'h82, 8'h00, 8'h00, 3, 1'b0);
		repeat (3) @(posedge hclk);
		`CHK(nval, 1)
		`CHK(got, 16'h0006)
		xfer(a_conv, 1, 0);
		repeat (3) @(posedge hclk);
		`CHK(converter_buffer_on, 1'b1)
	endtask
	task automatic t_codes;
		logic [15:0] c[7] = '{16'h0, 16'h045d, 16'h0ba2, 16'h68ba, 16'hc5d1, 16'hda2e, 16'hffff};
		logic [21:0] v;
		foreach (c[i]) begin
			xfer(a_dac, 1, {16'h0, c[i]});
			repeat (3) @(posedge hclk);
			v = 22'd300000 + 22'((64'(c[i]) * 64'd2200000) >> 16);
			`CHK(vout_uv, v)
			xfer(a_stat, 0, 0);
			`CHK(r[3:1], {c[i] == 16'hda2e, c[i] == 16'h045d, c[i] >= 16'h0ba2 && c[i] <= 16'hc5d1})
		end
		host.send(8'h01, 8'h04, 8'h5d, 3, 1'b0);
		repeat (3) @(posedge hclk);
		`CHK(dac_code, 16'h045d)
	endtask
	task automatic print_verdict;
		if (n_fail == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_crc;
		t_sdo;
		t_codes;
		print_verdict;
	end
endmodule // dac_setup_test
bind dac_setup dac_setup_assertions #(.CODE_W(CODE_W)) chk (.*);
`default_nettype wire

// >>> serial_host.sv
// host model sending serial frames with checksum
// assumes bytes are sampled on rising hclk
`timescale 1ns/1ns
`default_nettype none
module serial_host (
	// clock
	input wire logic hclk,
	// frame lines
	output logic frame_start,
	output logic rx_valid,
	output logic [7:0] rx_byte
);
	initial begin
		frame_start = 1'b0;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
	end
	// ----------------------------------------
	// checksum and frame sending
	// ----------------------------------------
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		c = c ^ d;
		for (int i = 0; i < 8; i++)
			c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		return c;
	endfunction
	// bad flips bit 0 of the checksum
	task automatic send(input logic [7:0] b0, b1, b2, input int n, input logic bad);
		logic [7:0] f[4];
		f = '{b0, b1, b2, crc8(crc8(crc8(8'h00, b0), b1), b2) ^ {7'h0, bad}};
		@(posedge hclk) frame_start <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge hclk) frame_start <= 1'b0;
			rx_valid <= 1'b1;
			rx_byte <= f[i];
		end
		@(posedge hclk) rx_valid <= 1'b0;
		rx_byte <= ~rx_byte;
	endtask
endmodule // serial_host
`default_nettype wire
